/* File: src/hac_clock.sv */
// hac_clock.sv: time-of-day clock with alarm, seconds/minutes/hours plus alarm time
// assumes key inputs are debounced, synchronous, one clean pulse per press
//
// Functional notes
// - hours 0..23, minutes 0..59 held
// - time key held: hour/minute keys add one
// - alarm key held: hour/minute keys step alarm
// - all time values wrap to 00
// - base tick period configurable, default 10 ms
// - chained counters modulo 60, 60, 24
// - stage at maximum clocks the next stage
// - two setting clocks from key combinations
// - alarm when hour and minute both equal
// - 1 Hz square wave, 0.50 s high
// - stages change only on rising input clock
// - hour clears at 23, clear is carry
// - max compare latched on falling input clock edge
// - setting clock ORed into increment, adds one
// - alarm counters own clocks, simple wrap
// - every stage shows byte-wide count
`timescale 1ns/1ps
`default_nettype none
`include "hac_defs.svh"

module hac_clock #(
  parameter int unsigned TICK_CYC = `HAC_BASE_TICK_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // keys
  input wire logic key_time_set,
  input wire logic key_alarm_set,
  input wire logic key_hour,
  input wire logic key_minute,
  // time values
  output logic [7:0] sec_q,
  output logic [7:0] min_q,
  output logic [7:0] hour_q,
  output logic [7:0] alarm_min_q,
  output logic [7:0] alarm_hour_q,
  // status
  output logic wave_1hz,
  output logic alarm
);

  // ==========================================================
  // helpers
  function automatic logic at_max(input logic [7:0] v, input logic [7:0] mx);
    at_max = (v == mx);
  endfunction

  function automatic logic [7:0] step(input logic [7:0] v, input logic [7:0] mx);
    step = at_max(v, mx) ? `HAC_ZERO : v + `HAC_ONE;
  endfunction

  // ==========================================================
  // base tick divider
  logic [31:0] tick_cnt_q;
  logic base_tick;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_cnt_q <= '0;
    end else if (tick_cnt_q == TICK_CYC - 1) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  assign base_tick = (tick_cnt_q == TICK_CYC - 1);

  // ==========================================================
  // 1 Hz square wave timebase
  logic [7:0] half_cnt_q;
  hac_pkg::hac_wave_t wave_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      half_cnt_q <= `HAC_ZERO;
      wave_q <= hac_pkg::HAC_WAVE_LOW;
    end else if (base_tick) begin
      if (half_cnt_q == 8'(`HAC_HALF_TICKS - 1)) begin
        half_cnt_q <= `HAC_ZERO;
        wave_q <= (wave_q == hac_pkg::HAC_WAVE_HIGH) ?
                  hac_pkg::HAC_WAVE_LOW : hac_pkg::HAC_WAVE_HIGH;
      end else begin
        half_cnt_q <= half_cnt_q + `HAC_ONE;
      end
    end
  end

  assign wave_1hz = (wave_q == hac_pkg::HAC_WAVE_HIGH);

  // ==========================================================
  // stage input clocks as levels, with edge detection
  logic sec_clr_q;
  logic min_clr_q;
  logic wave_d1_q;
  logic wave_rise;
  logic wave_fall;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wave_d1_q <= 1'b0;
    end else begin
      wave_d1_q <= wave_1hz;
    end
  end

  assign wave_rise = wave_1hz & ~wave_d1_q;
  assign wave_fall = ~wave_1hz & wave_d1_q;

  // ==========================================================
  // setting clocks
  logic set_min;
  logic set_hour;
  logic al_min_clk;
  logic al_hour_clk;

  assign set_min = key_time_set & key_minute;
  assign set_hour = key_time_set & key_hour;
  assign al_min_clk = key_alarm_set & key_minute;
  assign al_hour_clk = key_alarm_set & key_hour;

  // ==========================================================
  // clear feedback, registered on the falling input edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sec_clr_q <= 1'b0;
    end else if (wave_fall) begin
      sec_clr_q <= at_max(sec_q, `HAC_SEC_MAX);
    end
  end

  // minute flag also follows key steps, so a key set to 59 cannot leave it stale
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      min_clr_q <= 1'b0;
    end else if (set_min) begin
      min_clr_q <= at_max(step(min_q, `HAC_MIN_MAX), `HAC_MIN_MAX);
    end else if (wave_fall) begin
      min_clr_q <= at_max(min_q, `HAC_MIN_MAX);
    end
  end

  // ==========================================================
  // carries: clear condition at rising input clock is the next stage clock
  logic sec_carry;
  logic min_tick;
  logic min_carry;
  logic hour_tick;

  assign sec_carry = wave_rise & sec_clr_q & at_max(sec_q, `HAC_SEC_MAX);
  assign min_tick = sec_carry | set_min;
  assign min_carry = sec_carry & min_clr_q & at_max(min_q, `HAC_MIN_MAX);
  assign hour_tick = min_carry | set_hour;

  // ==========================================================
  // seconds stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sec_q <= `HAC_ZERO;
    end else if (wave_rise) begin
      if (sec_clr_q && at_max(sec_q, `HAC_SEC_MAX)) begin
        sec_q <= `HAC_ZERO;
      end else begin
        sec_q <= step(sec_q, `HAC_SEC_MAX);
      end
    end
  end

  // ==========================================================
  // minutes stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      min_q <= `HAC_ZERO;
    end else if (min_tick) begin
      min_q <= step(min_q, `HAC_MIN_MAX);
    end
  end

  // ==========================================================
  // hours stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hour_q <= `HAC_ZERO;
    end else if (hour_tick) begin
      hour_q <= step(hour_q, `HAC_HOUR_MAX);
    end
  end

  // ==========================================================
  // alarm time counters
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      alarm_min_q <= `HAC_ZERO;
    end else if (al_min_clk) begin
      alarm_min_q <= step(alarm_min_q, `HAC_MIN_MAX);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      alarm_hour_q <= `HAC_ZERO;
    end else if (al_hour_clk) begin
      alarm_hour_q <= step(alarm_hour_q, `HAC_HOUR_MAX);
    end
  end

  // ==========================================================
  // alarm compare
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      alarm <= 1'b0;
    end else begin
      alarm <= (hour_q == alarm_hour_q) && (min_q == alarm_min_q);
    end
  end

endmodule

`default_nettype wire

/* File: src/hac_defs.svh */
// hac_defs.svh: constants for the hour/minute clock with alarm
// assumes a 100 MHz system clock and debounced single-cycle key pulses
`ifndef HAC_DEFS_SVH
`define HAC_DEFS_SVH

`define HAC_CLK_PERIOD_NS 10
`define HAC_BASE_TICK_MS 10
`define HAC_BASE_TICK_CYC ((`HAC_BASE_TICK_MS * 1000000) / `HAC_CLK_PERIOD_NS)
`define HAC_HALF_PERIOD_CS 50
`define HAC_TICK_CS_MS 10
`define HAC_HALF_TICKS (`HAC_HALF_PERIOD_CS * `HAC_TICK_CS_MS / `HAC_BASE_TICK_MS)
`define HAC_SEC_MAX 8'h3B
`define HAC_MIN_MAX 8'h3B
`define HAC_HOUR_MAX 8'h17
`define HAC_ZERO 8'h00
`define HAC_ONE 8'h01

`endif

/* File: src/hac_pkg.sv */
// hac_pkg.sv: shared types for the hour/minute clock with alarm
// assumes nothing beyond the defs header
package hac_pkg;
  typedef logic [7:0] hac_count_t;
  typedef enum logic [0:0] {
    HAC_WAVE_LOW = 1'b0,
    HAC_WAVE_HIGH = 1'b1
  } hac_wave_t;
endpackage

/* File: verif/hac_clock_properties.sv */
// hac_clock_properties.sv: port checks for the clock with alarm
// assumes it is bound onto every hac_clock instance
`timescale 1ns/1ps
`default_nettype none
// =====
// checker
module hac_clock_checker (
  // clock, reset and keys
  input wire logic clk,
  input wire logic rst_n,
  input wire logic key_time_set,
  input wire logic key_alarm_set,
  input wire logic key_hour,
  input wire logic key_minute,
  // counts and status
  input wire logic [7:0] sec_q,
  input wire logic [7:0] min_q,
  input wire logic [7:0] hour_q,
  input wire logic [7:0] alarm_min_q,
  input wire logic [7:0] alarm_hour_q,
  input wire logic wave_1hz,
  input wire logic alarm
);
  logic eq;
  assign eq = (hour_q == alarm_hour_q) && (min_q == alarm_min_q);
  function automatic logic [7:0] nx(input logic [7:0] v, input logic [7:0] m);
    return (v == m) ? 8'h00 : v + 8'h01;
  endfunction
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_range; min_q <= 8'h3B && hour_q <= 8'h17; endproperty
  a_range: assert property (p_range) else $error("time out of range");
  property p_tmin; key_time_set && key_minute |=> min_q == nx($past(min_q), 8'h3B); endproperty
  a_tmin: assert property (p_tmin) else $error("minute step");
  property p_ahour; key_alarm_set && key_hour |=> alarm_hour_q == nx($past(alarm_hour_q), 8'h17);
  endproperty
  a_ahour: assert property (p_ahour) else $error("alarm hour step");
  property p_ahold; !key_alarm_set |=> $stable(alarm_hour_q) && $stable(alarm_min_q); endproperty
  a_ahold: assert property (p_ahold) else $error("alarm time moved");
  property p_alarm; $past(rst_n) |-> alarm == $past(eq); endproperty
  a_alarm: assert property (p_alarm) else $error("alarm compare");
  property p_sec; $rose(wave_1hz) |=> sec_q == nx($past(sec_q), 8'h3B); endproperty
  a_sec: assert property (p_sec) else $error("second step");
  property p_sechold; $stable(wave_1hz) |=> $stable(sec_q); endproperty
  a_sechold: assert property (p_sechold) else $error("second moved");
  property p_carry; $rose(wave_1hz) && sec_q == 8'h3B && min_q == 8'h3B
    |=> hour_q == nx($past(hour_q), 8'h17); endproperty
  a_carry: assert property (p_carry) else $error("hour carry");
endmodule
bind hac_clock hac_clock_checker u_hac_clock_checker (.*);
`default_nettype wire

/* File: verif/hac_key_pad.sv */
// hac_key_pad.sv: key pad and alarm lamp at the clock's far side
// assumes the clock samples keys on the rising clk
`timescale 1ns/1ps
`default_nettype none
// =====
// key pad
module hac_key_pad (
  // clock and alarm lamp
  input wire logic clk,
  input wire logic alarm,
  // debounced keys
  output logic key_time_set,
  output logic key_alarm_set,
  output logic key_hour,
  output logic key_minute
);
  initial {key_time_set, key_alarm_set, key_hour, key_minute} = 4'h0;
  // one clean press, changed at falling clk, released after one cycle
  task automatic press(input logic [3:0] k);
    @(negedge clk) {key_time_set, key_alarm_set, key_hour, key_minute} = k;
    @(negedge clk) {key_time_set, key_alarm_set, key_hour, key_minute} = 4'h0;
  endtask
endmodule
`default_nettype wire

/* File: verif/test_hac_clock.sv */
// test_hac_clock.sv: self-checking bench for the clock with alarm
// assumes hac_clock, its checker and the key pad model
`timescale 1ns/1ps
`default_nettype none
// =====
// bench
module test_hac_clock;
  logic clk, rst_n, key_time_set, key_alarm_set, key_hour, key_minute, wave_1hz, alarm;
  logic [7:0] sec_q, min_q, hour_q, alarm_min_q, alarm_hour_q, th, tm, ah, am;
  logic [32:0] q[$];
  int error_cnt, n_checks;
  event done_ev;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  hac_clock #(.TICK_CYC(2)) u_hac_clock (
    .clk(clk),
    .rst_n(rst_n),
    .key_time_set(key_time_set),
    .key_alarm_set(key_alarm_set),
    .key_hour(key_hour),
    .key_minute(key_minute),
    .sec_q(sec_q),
    .min_q(min_q),
    .hour_q(hour_q),
    .alarm_min_q(alarm_min_q),
    .alarm_hour_q(alarm_hour_q),
    .wave_1hz(wave_1hz),
    .alarm(alarm)
  );
  hac_key_pad u_hac_key_pad (
    .clk(clk),
    .alarm(alarm),
    .key_time_set(key_time_set),
    .key_alarm_set(key_alarm_set),
    .key_hour(key_hour),
    .key_minute(key_minute)
  );
  function automatic logic [7:0] nx(input logic [7:0] v, input logic [7:0] m);
    return (v == m) ? 8'h00 : v + 8'h01;
  endfunction
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // key bits: time set, alarm set, hour, minute
  task automatic hit(input logic [3:0] k);
    u_hac_key_pad.press(k);
    if (k[3] && k[1]) th = nx(th, 8'h17);
    if (k[3] && k[0]) tm = nx(tm, 8'h3B);
    if (k[2] && k[1]) ah = nx(ah, 8'h17);
    if (k[2] && k[0]) am = nx(am, 8'h3B);
    @(negedge clk);
    q.push_back({th, tm, ah, am, th == ah && tm == am});
    ->done_ev;
  endtask
  always @(done_ev) chk({hour_q, min_q, alarm_hour_q, alarm_min_q, alarm}, q.pop_front());
  initial begin
    rst_n = 1'b0;
    {th, tm, ah, am} = 32'h0;
    void'($urandom(32'hC0140990));
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk({hour_q, min_q, alarm_hour_q, alarm_min_q, alarm}, 33'h1);
    chk({24'h0, sec_q, wave_1hz}, 33'h0);
    $display("test reset done");
    repeat (40) hit(4'($urandom_range(15)));
    $display("test random keys done");
    do hit(4'h9); while (tm != 8'h3B);
    while (th != 8'h17) hit(4'hA);
    while (ah != 8'h00 || am != 8'h00) hit({2'b01, ah != 8'h00, am != 8'h00});
    $display("test wraps done");
    for (int i = 0; i < 13000 && hour_q !== 8'h00; i++) @(negedge clk);
    if (hour_q !== 8'h00) begin
      error_cnt++;
      $display("FAIL %0t rollover timeout", $time);
    end
    {th, tm} = 16'h0;
    @(negedge clk);
    chk({hour_q, min_q, alarm_hour_q, alarm_min_q, alarm}, {th, tm, ah, am, 1'b1});
    $display("test rollover done");
    wrap_up();
  end
endmodule
`default_nettype wire
